// file: hdl/scpi_parser_map.svh
// constants for the text command parser: characters, limits, reset values
// assumes nothing; included by bare name wherever a figure is needed
`ifndef SCPI_PARSER_MAP_SVH
`define SCPI_PARSER_MAP_SVH
`define CH_LF 8'h0a
`define CH_CR 8'h0d
`define CH_SPACE 8'h20
`define CH_QUOTE 8'h22
`define CH_STAR 8'h2a
`define CH_COMMA 8'h2c
`define CH_DOT 8'h2e
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_COLON 8'h3a
`define CH_QMARK 8'h3f
`define CH_UP_A 8'h41
`define CH_UP_Z 8'h5a
`define CH_LO_A 8'h61
`define CH_LO_Z 8'h7a
`define CASE_BIT 8'h20
`define KW_COUNT 18
`define KBUF_CHARS 4'h8
`define MAX_DIGITS 3'h6
`define FRAC_DIGITS 2'h3
`define CONTRAST_MIN 20'h1
`define CONTRAST_MAX 20'h3
`define CONTRAST_RST 2'h1
`define RCL_MAX 20'h5
`define BOOL_MAX 20'h1
`define CURR_MAX_DEF 32'h5dc
`define ERR_NONE 2'h0
`define ERR_SYNTAX 2'h1
`define ERR_EXEC 2'h2
`define FIFO_DEPTH 32
`define CLK_HZ 100000000
`define LONG_PRESS_MS 1000
`endif

// file: hdl/scpi_parser_pkg.sv
// types shared by the text command parser and its input buffer
// assumes the constants header is included alongside
package scpi_parser_pkg;
  typedef enum logic [4:0] {KW_NONE, KW_SYST, KW_BEEP, KW_STAT, KW_OUTP, KW_DISP, KW_CONT, KW_TEXT, KW_CURR,
    KW_SOUR, KW_LOC, KW_REM, KW_ERR, KW_RCL, KW_ON, KW_OFF, KW_MIN, KW_MAX} kw_e;
  typedef enum logic [4:0] {S_KEY = 5'h01, S_PARAM = 5'h02, S_STR = 5'h04, S_SKIP = 5'h08, S_RESP = 5'h10} state_e;
  typedef enum logic [1:0] {P_NONE, P_NUM, P_WORD, P_STR} pkind_e;
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } rx_byte_s;
  typedef struct packed {
    state_e state;
    logic [63:0] kbuf;
    logic [3:0] klen;
    logic [1:0] lvl;
    kw_e [2:0] path;
    logic query;
    pkind_e pkind;
    logic [19:0] pval;
    logic [2:0] ndig;
    logic dot;
    logic [1:0] frac;
    logic [7:0] slen;
    logic [1:0] pcnt;
    pkind_e p1kind;
    kw_e p1word;
    logic [19:0] p1val;
    logic p1dot;
    logic [1:0] p1frac;
    logic [7:0] p1slen;
    logic bad;
    logic [1:0] err_code;
    logic tx_valid;
    logic [7:0] tx_data;
    logic beep;
    logic outp;
    logic [1:0] contrast;
    logic rcl_v;
    logic [2:0] rcl_slot;
    logic [15:0] curr;
    logic text_v;
    logic [7:0] text_len;
    logic remote;
    logic lock;
    logic key_s1;
    logic key_s2;
    logic lock_s1;
    logic lock_s2;
    logic [31:0] press_cnt;
    logic press_done;
  } st_s;
endpackage

// file: hdl/scpi_parser.sv
// text command parser with its input byte buffer
// assumes a byte stream from the remote link on sys_clk and a response sink with ready
`timescale 1ns/10ps
`include "scpi_parser_map.svh"

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } fst_s;
  fst_s q, n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  always_comb begin
    push = in_valid && q.rdy;
    pop = out_ready && (q.cnt != '0);
    n = q;
    if (push) n.wp = q.wp + 1'h1;
    if (pop) n.rp = q.rp + 1'h1;
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // registered ready: one slot of slack is never needed since cnt is exact
    n.rdy = n.cnt != (AW+1)'(DEPTH);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
  assign in_ready = q.rdy;
  assign out_valid = q.cnt != '0;
  assign out_data = mem[q.rp];
endmodule // byte_fifo

// Operation
// - commands are a root keyword and lower keywords, colon separated
// - a space separates the last keyword from the first parameter
// - a keyword path ending in question mark is a query and gets a reply; only OUTP, SYST:BEEP, DISP:CONT and SYST:ERR queries do
// - several parameters of one command are separated by commas
// - optional keywords may be present or absent with identical effect
// - keyword matching ignores letter case
// - only the full form or the capitals-only short form of a keyword matches
// - line feed ends a command; carriage return plus line feed and eoi too
// - after every terminator the keyword path returns to the root
// - every reply ends with byte 0x0a
// - booleans take ON, OFF, 1 or 0
// - discrete parameters take only listed values, recall slots 0 to 5
// - integer parameters are range checked, contrast 1 to 3
// - real parameters take values in range, or MINimum and MAXimum
// - string parameters are ascii characters
// - local command or long unlock press leaves remote and dims its indicator; a command executed in the press's last cycle keeps remote lit
// - releasing the panel lock dims the lock indicator
module scpi_parser
  import scpi_parser_pkg::*;
#(
  parameter logic [31:0] CURR_MAX = `CURR_MAX_DEF,
  parameter int LONG_PRESS_CYC = `LONG_PRESS_MS * (`CLK_HZ / 1000)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eoi,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic unlock_key,
  input wire logic panel_lock,
  output logic beeper_en,
  output logic output_en,
  output logic [1:0] contrast,
  output logic recall_valid,
  output logic [2:0] recall_slot,
  output logic [15:0] current_set,
  output logic text_valid,
  output logic [7:0] text_len,
  output logic remote_indicator,
  output logic lock_indicator,
  output logic [1:0] err_code
);
  localparam logic [63:0] KW_STR [`KW_COUNT] = '{64'h0, 64'("SYSTEM"), 64'("BEEPER"), 64'("STATE"), 64'("OUTPUT"),
    64'("DISPLAY"), 64'("CONTRAST"), 64'("TEXT"), 64'("CURRENT"), 64'("SOURCE"), 64'("LOCAL"), 64'("REMOTE"),
    64'("ERROR"), 64'("*RCL"), 64'("ON"), 64'("OFF"), 64'("MINIMUM"), 64'("MAXIMUM")};
  localparam int KW_LONG [`KW_COUNT] = '{0, 6, 6, 5, 6, 7, 8, 4, 7, 6, 5, 6, 5, 4, 2, 3, 7, 7};
  localparam int KW_SHORT [`KW_COUNT] = '{0, 4, 4, 4, 4, 4, 4, 4, 4, 4, 3, 3, 3, 4, 2, 3, 3, 3};

  st_s q, n;
  rx_byte_s f_data;
  logic f_valid, f_ready, fire, term;
  logic [7:0] c;

  function automatic logic [7:0] upcase(logic [7:0] b);
    return (b >= `CH_LO_A && b <= `CH_LO_Z) ? (b & ~`CASE_BIT) : b;
  endfunction

  function automatic kw_e kw_find(logic [63:0] kb, logic [3:0] len);
    kw_e r;
    r = KW_NONE;
    for (int i = 1; i < `KW_COUNT; i++) begin
      // short form is the leading capitals only; any other cut fails
      if ((32'(len) == KW_LONG[i] && kb == KW_STR[i]) ||
          (32'(len) == KW_SHORT[i] && kb == (KW_STR[i] >> (8 * (KW_LONG[i] - KW_SHORT[i]))))) begin
        r = kw_e'(5'(i));
      end
    end
    return r;
  endfunction

  function automatic st_s clr_tok(st_s s);
    s.kbuf = '0;
    s.klen = '0;
    s.pkind = P_NONE;
    s.pval = '0;
    s.ndig = '0;
    s.dot = '0;
    s.frac = '0;
    s.slen = '0;
    return s;
  endfunction

  function automatic st_s end_kw(st_s s);
    kw_e k;
    k = kw_find(s.kbuf, s.klen);
    if (s.klen != '0) begin
      if (k == KW_NONE || k >= KW_ON || s.lvl == 2'h3) begin
        s.state = S_SKIP;
      end else if (!((k == KW_STAT && s.lvl != '0) || (k == KW_SOUR && s.lvl == '0))) begin
        s.path[s.lvl] = k;
        s.lvl = s.lvl + 2'h1;
      end
      // optional keywords are dropped so both spellings decode alike
    end
    s.kbuf = '0;
    s.klen = '0;
    return s;
  endfunction

  function automatic st_s end_param(st_s s, logic comma);
    kw_e k;
    k = kw_find(s.kbuf, s.klen);
    if (s.klen != '0) begin
      s.pkind = P_WORD;
    end
    if (s.pkind == P_NONE) begin
      if (comma || s.pcnt != '0) s.state = S_SKIP;
    end else if (s.pkind == P_WORD && k < KW_ON) begin
      s.state = S_SKIP;
    end else begin
      if (s.pcnt == '0) begin
        s.p1kind = s.pkind;
        s.p1word = k;
        s.p1val = s.pval;
        s.p1dot = s.dot;
        s.p1frac = s.frac;
        s.p1slen = s.slen;
      end
      if (s.pcnt != 2'h3) s.pcnt = s.pcnt + 2'h1;
    end
    return clr_tok(s);
  endfunction

  function automatic st_s exec_cmd(st_s s, logic [31:0] cmax);
    logic ok, rsp, set, qry, noarg, isbool, bv, isint;
    logic [1:0] d;
    logic [31:0] v;
    kw_e a, b;
    a = s.path[0];
    b = s.path[1];
    ok = '0;
    rsp = '0;
    d = '0;
    set = !s.query && s.pcnt == 2'h1;
    qry = s.query && s.pcnt == '0;
    noarg = !s.query && s.pcnt == '0;
    isint = s.p1kind == P_NUM && !s.p1dot;
    isbool = (isint && s.p1val <= `BOOL_MAX) || (s.p1kind == P_WORD && (s.p1word == KW_ON || s.p1word == KW_OFF));
    bv = (s.p1kind == P_NUM) ? s.p1val[0] : (s.p1word == KW_ON);
    // fixed point at three decimals: pad missing fraction digits
    case (s.p1frac)
      2'h0: v = 32'(s.p1val) * 32'h3e8;
      2'h1: v = 32'(s.p1val) * 32'h64;
      2'h2: v = 32'(s.p1val) * 32'ha;
      default: v = 32'(s.p1val);
    endcase
    if (s.lvl == '0) begin
      ok = '1;
    end else if (s.lvl == 2'h2 && a == KW_SYST && b == KW_BEEP) begin
      if (set && isbool) begin s.beep = bv; ok = '1; end
      else if (qry) begin d = {1'h0, s.beep}; rsp = '1; ok = '1; end
    end else if (s.lvl == 2'h1 && a == KW_OUTP) begin
      if (set && isbool) begin s.outp = bv; ok = '1; end
      else if (qry) begin d = {1'h0, s.outp}; rsp = '1; ok = '1; end
    end else if (s.lvl == 2'h2 && a == KW_DISP && b == KW_CONT) begin
      if (set && isint && s.p1val >= `CONTRAST_MIN && s.p1val <= `CONTRAST_MAX) begin
        s.contrast = s.p1val[1:0];
        ok = '1;
      end else if (qry) begin d = s.contrast; rsp = '1; ok = '1; end
    end else if (s.lvl == 2'h2 && a == KW_DISP && b == KW_TEXT) begin
      if (set && s.p1kind == P_STR) begin s.text_v = '1; s.text_len = s.p1slen; ok = '1; end
    end else if (s.lvl == 2'h1 && a == KW_CURR && set) begin
      if (s.p1kind == P_WORD && s.p1word == KW_MIN) begin s.curr = '0; ok = '1; end
      else if (s.p1kind == P_WORD && s.p1word == KW_MAX) begin s.curr = cmax[15:0]; ok = '1; end
      else if (s.p1kind == P_NUM && v <= cmax) begin s.curr = v[15:0]; ok = '1; end
    end else if (s.lvl == 2'h2 && a == KW_SYST && (b == KW_LOC || b == KW_REM) && noarg) begin
      ok = '1;
    end else if (s.lvl == 2'h2 && a == KW_SYST && b == KW_ERR && qry) begin
      d = s.err_code;
      s.err_code = `ERR_NONE;
      rsp = '1;
      ok = '1;
    end else if (s.lvl == 2'h1 && a == KW_RCL && set && isint && s.p1val <= `RCL_MAX) begin
      s.rcl_v = '1;
      s.rcl_slot = s.p1val[2:0];
      ok = '1;
    end
    if (!ok) begin
      s.bad = '1;
      s.err_code = `ERR_EXEC;
    end else if (s.lvl != '0) begin
      s.remote = !(a == KW_SYST && b == KW_LOC);
    end
    if (rsp) begin
      s.tx_valid = '1;
      s.tx_data = `CH_ZERO + {6'h0, d};
      s.state = S_RESP;
    end
    return s;
  endfunction

  byte_fifo #(.WIDTH($bits(rx_byte_s)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_data, rx_eoi}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // replies stall the input so the buffer really fills under back-pressure
  assign f_ready = q.state != S_RESP;

  always_comb begin
    n = q;
    fire = '0;
    term = '0;
    c = '0;
    n.rcl_v = '0;
    n.text_v = '0;
    n.bad = '0;
    n.key_s1 = unlock_key;
    n.key_s2 = q.key_s1;
    n.lock_s1 = panel_lock;
    n.lock_s2 = q.lock_s1;
    n.lock = q.lock_s2;
    if (!q.key_s2) begin
      n.press_cnt = '0;
      n.press_done = '0;
    end else if (!q.press_done) begin
      if (q.press_cnt == 32'(LONG_PRESS_CYC - 1)) begin
        fire = '1;
        n.press_done = '1;
        n.remote = '0;
      end else begin
        n.press_cnt = q.press_cnt + 32'h1;
      end
    end
    if (q.state == S_RESP) begin
      if (tx_ready) begin
        if (q.tx_data == `CH_LF) begin
          n.tx_valid = '0;
          n.state = S_KEY;
        end else begin
          n.tx_data = `CH_LF;
        end
      end
    end else if (f_valid) begin
      c = upcase(f_data.data);
      term = f_data.data == `CH_LF || f_data.eoi;
      unique case (q.state)
        S_KEY: begin
          if (c == `CH_COLON) begin
            n = end_kw(n);
          end else if (c == `CH_SPACE) begin
            n.state = S_PARAM;
            n = end_kw(n);
          end else if (c == `CH_QMARK) begin
            n.state = S_PARAM;
            n.query = '1;
            n = end_kw(n);
          end else if ((c >= `CH_UP_A && c <= `CH_UP_Z) || c == `CH_STAR) begin
            if (q.klen == `KBUF_CHARS) n.state = S_SKIP;
            else begin
              n.kbuf = {q.kbuf[55:0], c};
              n.klen = q.klen + 4'h1;
            end
          end else if (c != `CH_CR && c != `CH_LF) begin
            n.state = S_SKIP;
          end
        end
        S_PARAM: begin
          if (c == `CH_COMMA) begin
            n = end_param(n, 1'h1);
          end else if (c == `CH_QUOTE && q.pkind == P_NONE && q.klen == '0) begin
            n.state = S_STR;
          end else if (c >= `CH_ZERO && c <= `CH_NINE && q.klen == '0 && q.pkind != P_STR) begin
            if (q.ndig == `MAX_DIGITS || (q.dot && q.frac == `FRAC_DIGITS)) n.state = S_SKIP;
            else begin
              n.pkind = P_NUM;
              n.pval = 20'(q.pval * 20'ha + 20'(c - `CH_ZERO));
              n.ndig = q.ndig + 3'h1;
              n.frac = q.frac + {1'h0, q.dot};
            end
          end else if (c == `CH_DOT && q.pkind == P_NUM && !q.dot) begin
            n.dot = '1;
          end else if (c >= `CH_UP_A && c <= `CH_UP_Z && q.pkind == P_NONE && q.klen != `KBUF_CHARS) begin
            n.kbuf = {q.kbuf[55:0], c};
            n.klen = q.klen + 4'h1;
          end else if (c != `CH_SPACE && c != `CH_CR && c != `CH_LF) begin
            n.state = S_SKIP;
          end
        end
        S_STR: begin
          if (c == `CH_QUOTE) begin
            n.pkind = P_STR;
            n.state = S_PARAM;
          end else if (f_data.data[7] || q.slen == 8'hff) begin
            n.state = S_SKIP;
          end else begin
            n.slen = q.slen + 8'h1;
          end
        end
        S_SKIP: begin
        end
        default: n.state = S_SKIP;
      endcase
      if (term) begin
        if (n.state == S_STR) n.state = S_SKIP;
        if (n.state == S_KEY) n = end_kw(n);
        else if (n.state == S_PARAM) n = end_param(n, 1'h0);
        if (n.state == S_SKIP) begin
          n.bad = '1;
          n.err_code = `ERR_SYNTAX;
        end else begin
          n = exec_cmd(n, CURR_MAX);
        end
        n.lvl = '0;
        n.path = '0;
        n.query = '0;
        n.pcnt = '0;
        n.p1kind = P_NONE;
        n = clr_tok(n);
        if (n.state != S_RESP) n.state = S_KEY;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= S_KEY;
      q.contrast <= `CONTRAST_RST;
    end else begin
      q <= n;
    end
  end

  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign beeper_en = q.beep;
  assign output_en = q.outp;
  assign contrast = q.contrast;
  assign recall_valid = q.rcl_v;
  assign recall_slot = q.rcl_slot;
  assign current_set = q.curr;
  assign text_valid = q.text_v;
  assign text_len = q.text_len;
  assign remote_indicator = q.remote;
  assign lock_indicator = q.lock;
  assign err_code = q.err_code;

  sequence digit_sent;
    q.tx_valid && tx_ready && q.tx_data != `CH_LF;
  endsequence
  sequence newline_next;
    q.tx_valid && q.tx_data == `CH_LF;
  endsequence
  chk_reply_newline: assert property (@(posedge sys_clk) disable iff (rst) digit_sent |=> newline_next)
    else $error("reply digit not followed by line feed");
  chk_query_reply: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(q.state == S_RESP) |-> q.tx_valid && q.tx_data >= `CH_ZERO && q.tx_data <= `CH_NINE)
    else $error("query reply missing or not a digit");
  chk_path_root: assert property (@(posedge sys_clk) disable iff (rst)
    f_valid && f_ready && term |=> q.lvl == '0 && q.klen == '0 && !q.query)
    else $error("keyword path not back at root after terminator");
  chk_contrast_range: assert property (@(posedge sys_clk) disable iff (rst)
    contrast >= 2'(`CONTRAST_MIN) && contrast <= 2'(`CONTRAST_MAX))
    else $error("contrast out of range");
  chk_recall_slot: assert property (@(posedge sys_clk) disable iff (rst)
    recall_valid |-> 20'(recall_slot) <= `RCL_MAX && $past(f_valid))
    else $error("recall slot out of range");
  chk_current_range: assert property (@(posedge sys_clk) disable iff (rst) 32'(current_set) <= CURR_MAX)
    else $error("current setting above maximum");
  chk_long_press: assert property (@(posedge sys_clk) disable iff (rst) fire && !term |=> !remote_indicator)
    else $error("remote indicator not dimmed after long press");
  chk_lock_dim: assert property (@(posedge sys_clk) disable iff (rst) !panel_lock [*3] |=> !lock_indicator)
    else $error("lock indicator still lit after release");
  chk_bad_discard: assert property (@(posedge sys_clk) disable iff (rst)
    q.bad |-> q.err_code != `ERR_NONE && !recall_valid && !text_valid && $stable(current_set))
    else $error("failed command had an effect or left no error");
endmodule // scpi_parser

// file: tb/host_model.sv
// remote host model: sends command text on the byte handshake, collects replies
// assumes the parser's stream ports on sys_clk; changes its signals at the falling edge
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rq[$];
  logic stall = 1'b0;
  logic slow = 1'b0;
  int timeouts = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eoi = 1'b0;
    tx_ready = 1'b1;
  end
  // slow mode takes a reply byte only every other cycle
  always @(negedge sys_clk) tx_ready <= !stall && (!slow || !tx_ready);
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) rq.push_back(tx_data);
  end
  // a byte is held until taken; waits on a refusing buffer are bounded
  task automatic put(input logic [7:0] b, input logic e);
    int n;
    n = 0;
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_data = b;
    rx_eoi = e;
    while (!rx_ready && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (!rx_ready) timeouts++;
    @(posedge sys_clk);
  endtask
  // text is sent whole, ascii as given; eoi may mark the last byte
  task automatic send(input string s, input logic e);
    for (int i = 0; i < s.len(); i++) put(s[i], e && i == s.len() - 1);
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_eoi = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule // host_model

// file: tb/scpi_command_parser_test.sv
// self-checking bench for the text command parser
// assumes the parser and its buffer from hdl/, host model from tb/
`timescale 1ns/10ps
module scpi_command_parser_test;
  import scpi_parser_pkg::*;
  localparam logic [31:0] CMAX = 32'h4b0;
  localparam int LPC = 20;
  logic sys_clk, rst, rx_valid, rx_eoi, rx_ready, tx_valid, tx_ready, unlock_key, panel_lock;
  logic beeper_en, output_en, recall_valid, text_valid, remote_indicator, lock_indicator;
  logic [7:0] rx_data, tx_data, text_len;
  logic [1:0] contrast, err_code;
  logic [2:0] recall_slot;
  logic [15:0] current_set;
  int err_count = 0;
  int num_checks = 0;
  int rcl_n = 0;
  int txt_n = 0;
  // short long-press count keeps the run brief
  scpi_parser #(.CURR_MAX(CMAX), .LONG_PRESS_CYC(LPC)) DUT (.sys_clk(sys_clk), .rst(rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .unlock_key(unlock_key),
    .panel_lock(panel_lock), .beeper_en(beeper_en), .output_en(output_en), .contrast(contrast),
    .recall_valid(recall_valid), .recall_slot(recall_slot), .current_set(current_set),
    .text_valid(text_valid), .text_len(text_len), .remote_indicator(remote_indicator),
    .lock_indicator(lock_indicator), .err_code(err_code));
  host_model host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // one-cycle pulses are counted mid-cycle, where they have settled
  always @(negedge sys_clk) begin
    if (recall_valid === 1'b1) rcl_n++;
    if (text_valid === 1'b1) txt_n++;
  end
  task automatic results();
    err_count += host.timeouts;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input string s, input logic e = 1'b0);
    host.send(s, e);
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic reply(input logic [7:0] d);
    int n;
    n = 0;
    while (host.rq.size() < 2 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (host.rq.size() < 2) begin
      err_count++;
      results();
    end
    chk({8'h0, host.rq[0]}, {8'h0, d});
    chk({8'h0, host.rq[1]}, 16'h0a);
    host.rq.delete();
  endtask
  task automatic t_bool();
    string c[6] = '{"OUTP 1\n", "outp:stat off\n", "SYST:BEEP:STAT ON\r\n", "system:beeper 0",
      "Syst:Beep 1\n", "OUTPUT:STATE ON\n"};
    logic [1:0] e[6] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b10, 2'b11};
    for (int i = 0; i < 6; i++) begin
      cmd(c[i], i == 3);
      chk({14'h0, beeper_en, output_en}, {14'h0, e[i]});
    end
  endtask
  task automatic t_query();
    host.slow = 1'b1;
    host.send("OUTP?\n", 1'b0);
    reply(8'h31);
    host.send("syst:beep:stat?\n", 1'b0);
    reply(8'h31);
    host.slow = 1'b0;
    chk({15'h0, output_en}, 16'h1);
  endtask
  task automatic t_abbrev();
    cmd("OUTPU 0\n");
    chk({14'h0, err_code}, 16'h1);
    cmd("SY:BEEP 0\n");
    chk({14'h0, beeper_en, output_en}, 16'h3);
    host.send("SYST:ERR?\n", 1'b0);
    reply(8'h31);
    chk({14'h0, err_code}, 16'h0);
  endtask
  task automatic t_ranges();
    int r;
    r = rcl_n;
    cmd("DISP:CONT 0\n");
    chk({14'h0, err_code}, 16'h2);
    cmd("DISP:CONT 4\n");
    chk({14'h0, contrast}, 16'h1);
    cmd("disp:cont 3\n");
    chk({14'h0, contrast}, 16'h3);
    cmd("OUTP 2\n");
    chk({15'h0, output_en}, 16'h1);
    cmd("*RCL 6\n");
    chk(16'(rcl_n - r), 16'h0);
    cmd("*RCL 5\n");
    chk({10'h0, 3'(rcl_n - r), recall_slot}, 16'hd);
    cmd("*RCL 0\n");
    chk({13'h0, recall_slot}, 16'h0);
  endtask
  task automatic t_real();
    cmd("CURR MAX\n");
    chk(current_set, CMAX[15:0]);
    cmd("curr min\n");
    chk(current_set, 16'h0);
    cmd("SOUR:CURR 0.25\n");
    chk(current_set, 16'hfa);
    cmd("CURR 2\n");
    chk({err_code, current_set[13:0]}, 16'h80fa);
  endtask
  task automatic t_text();
    int t;
    t = txt_n;
    cmd("DISP:TEXT \"Hi, there\"\n");
    chk({text_len, 8'(txt_n - t)}, 16'h0901);
  endtask
  task automatic t_path();
    host.send("SYST:ERR?\n", 1'b0);
    reply(8'h32);
    cmd("SYST:BEEP 0\nSTAT 1\n");
    chk({13'h0, err_code, beeper_en}, 16'h4);
    cmd("OUTP 0,1\n");
    chk({15'h0, output_en}, 16'h1);
  endtask
  task automatic t_remote();
    cmd("SYST:LOC\n");
    chk({15'h0, remote_indicator}, 16'h0);
    cmd("syst:rem\n");
    unlock_key = 1'b1;
    repeat (LPC - 8) @(negedge sys_clk);
    unlock_key = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({15'h0, remote_indicator}, 16'h1);
    unlock_key = 1'b1;
    repeat (LPC + 6) @(negedge sys_clk);
    chk({15'h0, remote_indicator}, 16'h0);
    unlock_key = 1'b0;
    panel_lock = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk({15'h0, lock_indicator}, 16'h1);
    panel_lock = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk({15'h0, lock_indicator}, 16'h0);
  endtask
  // a pending reply stops draining, so the buffer must refuse
  task automatic t_fifo();
    host.stall = 1'b1;
    host.send("OUTP?\n", 1'b0);
    fork
      host.send("OUTP 0\nSYST:BEEP 1\nDISP:CONT 2\n\n\n\n\n\n", 1'b0);
    join_none
    repeat (45) @(negedge sys_clk);
    chk({15'h0, rx_ready}, 16'h0);
    host.stall = 1'b0;
    reply(8'h31);
    wait fork;
    // the buffer still holds a full backlog when the sender finishes
    repeat (40) @(negedge sys_clk);
    chk({12'h0, output_en, beeper_en, contrast}, 16'h6);
  endtask
  initial begin
    #500us;
    err_count++;
    results();
  end
  initial begin
    rst = 1'b1;
    unlock_key = 1'b0;
    panel_lock = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({13'h0, rx_ready, contrast}, 16'h1);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({15'h0, rx_ready}, 16'h1);
    t_bool();
    t_query();
    t_abbrev();
    t_ranges();
    t_real();
    t_text();
    t_path();
    t_remote();
    t_fifo();
    results();
  end
endmodule // scpi_command_parser_test
